//--- omsc_defines.svh
`ifndef OMSC_DEFINES_SVH
`define OMSC_DEFINES_SVH

// Word indices on the register bus
`define OMSC_IDX_MODE_MON 3'h0
`define OMSC_IDX_SYS_CTRL 3'h1
`define OMSC_IDX_IRQ_STAT 3'h2
`define OMSC_IDX_IRQ_MASK 3'h3

// Mode pin monitor fields
`define OMSC_MM_EXP_BIT 7
`define OMSC_MM_HIGH_BIT 2
`define OMSC_MM_LOW_BIT 1

// System control fields
`define OMSC_SC_INTM_HI_BIT 5
`define OMSC_SC_INTM_LO_BIT 4
`define OMSC_SC_RSTSRC_BIT 3
`define OMSC_SC_NMI_EDGE_SELECT_BIT 2
`define OMSC_SC_ONCHIP_RAM_ENABLE_BIT 0

// Reset values
`define OMSC_RST_EXP 1'h0
`define OMSC_RST_IRQ_CTRL_MODE_LOW 1'h0
`define OMSC_RST_RSTSRC_EXT 1'h1
`define OMSC_RST_RSTSRC_WDT 1'h0
`define OMSC_RST_NMI_EDGE_SELECT 1'h0
`define OMSC_RST_ONCHIP_RAM_ENABLE 1'h1
`define OMSC_RST_MASK 3'h0

// Fixed lowest mode-select level
`define OMSC_MODE_FIXED_LOW 1'h0

// Operating mode codes
`define OMSC_MODE_SINGLE 3'h2
`define OMSC_MODE_FLASH 3'h4
`define OMSC_MODE_EMUL 3'h6

// Interrupt status bit positions
`define OMSC_EV_NMI 0
`define OMSC_EV_WDT 1
`define OMSC_EV_BADMODE 2

`endif

//--- omsc_pkg.sv
package omsc_pkg;

    typedef enum logic [0:0] {
        OMSC_BUS_IDLE = 1'b0,
        OMSC_BUS_ACK = 1'b1
    } omsc_bus_t;

    typedef struct packed {
        logic [2:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } omsc_avreq_t;

    typedef struct packed {
        logic [2:0] opMode;
        logic modeValid;
        logic romEnable;
        logic flashBoot;
        logic emulationEnable;
        logic [1:0] irqCtrlMode;
        logic onchipRamEnable;
        logic nmiRequest;
    } omsc_ctrlout_t;

    typedef struct packed {
        omsc_bus_t bus;
        logic waitReq;
        logic [31:0] rdData;
        logic latched;
        logic latchedModeHigh;
        logic latchedModeLow;
        logic reservedExpansionBit;
        logic irqCtrlModeLow;
        logic resetSourceFlag;
        logic nmiEdgeSelect;
        logic onchipRamEnable;
        logic nmiPrev;
        logic [2:0] irqStatus;
        logic [2:0] irqMask;
        logic irq;
        omsc_ctrlout_t ctrl;
    } omsc_state_t;

endpackage : omsc_pkg

//--- omsc_ctrl.sv
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "omsc_defines.svh"

// Function
// RULE1 - decode high/low pins into modes 2, 4, 6
// RULE2 - lowest mode-select bit always reads zero
// RULE3 - board never straps modes 0,1,3,5,7
// RULE4 - board keeps mode pins stable after reset
// RULE5 - software reads monitor after reset to latch
// RULE6 - monitor bits 2,1 show pins, read-only
// RULE7 - pins captured into mode bits on read
// RULE8 - any reset releases latched mode bits
// RULE9 - interrupt mode field bits 5,4, low writable
// RULE10 - bit 3: 0 watchdog reset, 1 pin reset
// RULE11 - bit 2 selects NMI falling or rising edge
// RULE12 - mode 6 enables emulator control via JTAG
// RULE13 - bit 0 enables on-chip RAM, reset one
// RULE14 - reserved bits read zero, writes ignored; monitor bit 7 (reservedExpansionBit) is writable and reads back
module omsc_ctrl (
    input wire logic clk_sys, // System clock, 50 MHz
    input wire logic rst, // Async external pin reset, active high
    input wire logic wdtOverflowReset, // Watchdog overflow reset pulse
    input wire logic modeSelectHighPin, // Mode strap, high select
    input wire logic modeSelectLowPin, // Mode strap, low select
    input wire logic nmiIn, // NMI input level
    input wire omsc_pkg::omsc_avreq_t avReq, // Avalon-MM request
    output logic [31:0] avReadData, // Avalon-MM read data
    output logic avWaitRequest, // Avalon-MM wait request
    output omsc_pkg::omsc_ctrlout_t ctrlOut, // Mode and control outputs
    output logic irq // Level interrupt
);
    import omsc_pkg::*;

    omsc_state_t s_q;
    omsc_state_t s_d;

    logic effHigh;
    logic effLow;
    logic [2:0] effMode;
    logic [7:0] modeMonVal;
    logic [7:0] sysCtrlVal;
    logic nmiEdge;
    logic accept;
    logic [2:0] events;
    logic [2:0] w1c;
    logic beLow;

    always_comb begin
        // Latched values stand once the monitor has been read
        effHigh = s_q.latched ? s_q.latchedModeHigh : modeSelectHighPin; // RULE7
        effLow = s_q.latched ? s_q.latchedModeLow : modeSelectLowPin; // RULE7
        effMode = {effHigh, effLow, `OMSC_MODE_FIXED_LOW}; // RULE1 RULE2

        modeMonVal = 8'h00; // RULE14
        modeMonVal[`OMSC_MM_EXP_BIT] = s_q.reservedExpansionBit;
        modeMonVal[`OMSC_MM_HIGH_BIT] = effHigh; // RULE6
        modeMonVal[`OMSC_MM_LOW_BIT] = effLow; // RULE6

        sysCtrlVal = 8'h00; // RULE14
        sysCtrlVal[`OMSC_SC_INTM_HI_BIT] = 1'b0; // RULE9
        sysCtrlVal[`OMSC_SC_INTM_LO_BIT] = s_q.irqCtrlModeLow; // RULE9
        sysCtrlVal[`OMSC_SC_RSTSRC_BIT] = s_q.resetSourceFlag; // RULE10
        sysCtrlVal[`OMSC_SC_NMI_EDGE_SELECT_BIT] = s_q.nmiEdgeSelect; // RULE11
        sysCtrlVal[`OMSC_SC_ONCHIP_RAM_ENABLE_BIT] = s_q.onchipRamEnable; // RULE13

        // Falling edge when clear, rising edge when set
        nmiEdge = s_q.nmiEdgeSelect ? (nmiIn & ~s_q.nmiPrev)
                                    : (~nmiIn & s_q.nmiPrev); // RULE11

        accept = s_q.bus == OMSC_BUS_ACK;
        beLow = avReq.byteenable[0];

        events = 3'h0;
        events[`OMSC_EV_NMI] = nmiEdge;
        events[`OMSC_EV_BADMODE] = (effMode != `OMSC_MODE_SINGLE)
            && (effMode != `OMSC_MODE_FLASH)
            && (effMode != `OMSC_MODE_EMUL); // RULE3

        w1c = 3'h0;
        if (accept && avReq.write && beLow
            && avReq.address == `OMSC_IDX_IRQ_STAT) begin
            w1c = avReq.writedata[2:0];
        end

        s_d = s_q;
        s_d.nmiPrev = nmiIn;

        // One wait state: request seen, then answered next edge
        case (s_q.bus)
            OMSC_BUS_IDLE: begin
                if (avReq.read || avReq.write) begin
                    s_d.bus = OMSC_BUS_ACK;
                    s_d.waitReq = 1'b0;
                    s_d.rdData = 32'h0000_0000;
                    if (avReq.read) begin
                        case (avReq.address)
                            `OMSC_IDX_MODE_MON: begin
                                s_d.rdData[7:0] = modeMonVal;
                            end
                            `OMSC_IDX_SYS_CTRL: begin
                                s_d.rdData[7:0] = sysCtrlVal;
                            end
                            `OMSC_IDX_IRQ_STAT: begin
                                s_d.rdData[2:0] = s_q.irqStatus;
                            end
                            `OMSC_IDX_IRQ_MASK: begin
                                s_d.rdData[2:0] = s_q.irqMask;
                            end
                            default: begin
                                s_d.rdData = 32'h0000_0000;
                            end
                        endcase
                    end
                end
            end
            OMSC_BUS_ACK: begin
                s_d.bus = OMSC_BUS_IDLE;
                s_d.waitReq = 1'b1;
                if (avReq.read && avReq.address == `OMSC_IDX_MODE_MON
                    && !s_q.latched) begin
                    s_d.latched = 1'b1; // RULE7 RULE5
                    s_d.latchedModeHigh = modeSelectHighPin; // RULE7
                    s_d.latchedModeLow = modeSelectLowPin; // RULE7
                end
                if (avReq.write && beLow) begin
                    case (avReq.address)
                        `OMSC_IDX_MODE_MON: begin
                            s_d.reservedExpansionBit =
                                avReq.writedata[`OMSC_MM_EXP_BIT];
                        end
                        `OMSC_IDX_SYS_CTRL: begin
                            s_d.irqCtrlModeLow =
                                avReq.writedata[`OMSC_SC_INTM_LO_BIT]; // RULE9
                            s_d.nmiEdgeSelect =
                                avReq.writedata[`OMSC_SC_NMI_EDGE_SELECT_BIT]; // RULE11
                            s_d.onchipRamEnable =
                                avReq.writedata[`OMSC_SC_ONCHIP_RAM_ENABLE_BIT]; // RULE13
                        end
                        `OMSC_IDX_IRQ_MASK: begin
                            s_d.irqMask = avReq.writedata[2:0];
                        end
                        default: begin
                            s_d.irqMask = s_q.irqMask;
                        end
                    endcase
                end
            end
            default: begin
                s_d.bus = OMSC_BUS_IDLE;
                s_d.waitReq = 1'b1;
            end
        endcase

        // New events win over a clear in the same cycle
        s_d.irqStatus = (s_q.irqStatus & ~w1c) | events;
        s_d.irq = |(s_d.irqStatus & s_d.irqMask);

        s_d.ctrl.opMode = effMode; // RULE1
        s_d.ctrl.modeValid = ~events[`OMSC_EV_BADMODE];
        s_d.ctrl.romEnable = (effMode == `OMSC_MODE_SINGLE)
            || (effMode == `OMSC_MODE_EMUL);
        s_d.ctrl.flashBoot = effMode == `OMSC_MODE_FLASH;
        s_d.ctrl.emulationEnable = effMode == `OMSC_MODE_EMUL; // RULE12
        s_d.ctrl.irqCtrlMode = {1'b0, s_d.irqCtrlModeLow}; // RULE9
        s_d.ctrl.onchipRamEnable = s_d.onchipRamEnable; // RULE13
        s_d.ctrl.nmiRequest = nmiEdge; // RULE11

        // Watchdog reset clears the bank like a pin reset, except reset source reads 0 and the WDT status bit is set
        if (wdtOverflowReset) begin
            s_d.bus = OMSC_BUS_IDLE;
            s_d.waitReq = 1'b1;
            s_d.rdData = 32'h0000_0000;
            s_d.latched = 1'b0; // RULE8
            s_d.latchedModeHigh = 1'b0;
            s_d.latchedModeLow = 1'b0;
            s_d.reservedExpansionBit = `OMSC_RST_EXP;
            s_d.irqCtrlModeLow = `OMSC_RST_IRQ_CTRL_MODE_LOW;
            s_d.resetSourceFlag = `OMSC_RST_RSTSRC_WDT; // RULE10
            s_d.nmiEdgeSelect = `OMSC_RST_NMI_EDGE_SELECT;
            s_d.onchipRamEnable = `OMSC_RST_ONCHIP_RAM_ENABLE;
            s_d.irqMask = `OMSC_RST_MASK;
            s_d.irqStatus = 3'h0;
            s_d.irqStatus[`OMSC_EV_WDT] = 1'b1;
            s_d.irq = 1'b0;
            s_d.ctrl.irqCtrlMode = 2'h0;
            s_d.ctrl.onchipRamEnable = `OMSC_RST_ONCHIP_RAM_ENABLE;
            s_d.ctrl.nmiRequest = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q.bus <= OMSC_BUS_IDLE;
            s_q.waitReq <= 1'b1;
            s_q.rdData <= 32'h0000_0000;
            s_q.latched <= 1'b0; // RULE8
            s_q.latchedModeHigh <= 1'b0;
            s_q.latchedModeLow <= 1'b0;
            s_q.reservedExpansionBit <= `OMSC_RST_EXP;
            s_q.irqCtrlModeLow <= `OMSC_RST_IRQ_CTRL_MODE_LOW;
            s_q.resetSourceFlag <= `OMSC_RST_RSTSRC_EXT; // RULE10
            s_q.nmiEdgeSelect <= `OMSC_RST_NMI_EDGE_SELECT;
            s_q.onchipRamEnable <= `OMSC_RST_ONCHIP_RAM_ENABLE; // RULE13
            s_q.nmiPrev <= 1'b0;
            s_q.irqStatus <= 3'h0;
            s_q.irqMask <= `OMSC_RST_MASK;
            s_q.irq <= 1'b0;
            s_q.ctrl.opMode <= 3'h0;
            s_q.ctrl.modeValid <= 1'b0;
            s_q.ctrl.romEnable <= 1'b0;
            s_q.ctrl.flashBoot <= 1'b0;
            s_q.ctrl.emulationEnable <= 1'b0;
            s_q.ctrl.irqCtrlMode <= 2'h0;
            s_q.ctrl.onchipRamEnable <= `OMSC_RST_ONCHIP_RAM_ENABLE;
            s_q.ctrl.nmiRequest <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign avReadData = s_q.rdData;
    assign avWaitRequest = s_q.waitReq;
    assign ctrlOut = s_q.ctrl;
    assign irq = s_q.irq;

endmodule : omsc_ctrl

//--- omsc_ctrl_properties.sv
`timescale 1ns/1ps
module omsc_ctrl_properties (
    input wire logic clk_sys, // Clock
    input wire logic rst, // Pin reset
    input wire logic wdtOverflowReset, // Watchdog reset
    input wire logic modeSelectHighPin, // Strap high
    input wire logic modeSelectLowPin, // Strap low
    input wire logic nmiIn, // NMI level
    input wire omsc_pkg::omsc_avreq_t avReq, // Request
    input wire logic [31:0] avReadData, // Read data
    input wire logic avWaitRequest, // Wait
    input wire omsc_pkg::omsc_ctrlout_t ctrlOut, // Controls
    input wire logic irq // Interrupt
);
    import omsc_pkg::*;
    logic latchQ;
    logic done;
    assign done = !avWaitRequest && !wdtOverflowReset;
    // Set once a monitor read has frozen the mode bits
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) latchQ <= 1'b0;
        else if (wdtOverflowReset) latchQ <= 1'b0;
        else if (avReq.read && done && avReq.address == 3'h0) latchQ <= 1'b1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_fixed; ctrlOut.opMode[0] == 1'b0; endproperty
    a_fixed: assert property (p_fixed) else $error("mode bit 0 set");
    property p_decode; ctrlOut.modeValid == (ctrlOut.opMode inside
        {3'h2, 3'h4, 3'h6}) && ctrlOut.emulationEnable ==
        (ctrlOut.opMode == 3'h6); endproperty
    a_decode: assert property (p_decode) else $error("bad decode");
    property p_wait; (avReq.read || avReq.write) && avWaitRequest &&
        !wdtOverflowReset |=> !avWaitRequest ##1 avWaitRequest; endproperty
    a_wait: assert property (p_wait) else $error("bad wait");
    property p_ram; avReq.write && done && avReq.address == 3'h1 &&
        avReq.byteenable[0] |=> ctrlOut.onchipRamEnable ==
        $past(avReq.writedata[0]) && ctrlOut.irqCtrlMode ==
        {1'b0, $past(avReq.writedata[4])}; endproperty
    a_ram: assert property (p_ram) else $error("control lost");
    property p_intm; ctrlOut.irqCtrlMode[1] == 1'b0; endproperty
    a_intm: assert property (p_intm) else $error("mode field high");
    property p_nmi; ctrlOut.nmiRequest |-> $past(nmiIn) != $past(nmiIn, 2);
    endproperty
    a_nmi: assert property (p_nmi) else $error("NMI without edge");
    property p_hold; latchQ && !wdtOverflowReset |=>
        $stable(ctrlOut.opMode); endproperty
    a_hold: assert property (p_hold) else $error("latched mode moved");
    property p_follow; !latchQ && !rst && !wdtOverflowReset |=>
        ctrlOut.opMode == {$past(modeSelectHighPin),
        $past(modeSelectLowPin), 1'b0}; endproperty
    a_follow: assert property (p_follow) else $error("mode not live");
endmodule : omsc_ctrl_properties

bind omsc_ctrl omsc_ctrl_properties u_props (.clk_sys(clk_sys), .rst(rst),
    .wdtOverflowReset(wdtOverflowReset), .nmiIn(nmiIn),
    .modeSelectHighPin(modeSelectHighPin), .modeSelectLowPin(modeSelectLowPin),
    .avReq(avReq), .avReadData(avReadData), .avWaitRequest(avWaitRequest),
    .ctrlOut(ctrlOut), .irq(irq));

//--- omsc_strap_model.sv
`timescale 1ns/1ps
module omsc_strap_model (
    input wire logic clk_sys, // Clock
    input wire logic [2:0] modeReq, // Wanted mode
    output logic highPin, // Strap high
    output logic lowPin // Strap low
);
    logic [1:0] strap = 2'b01;
    // Unsupported modes are never strapped; the last strap is held
    always @(posedge clk_sys) begin
        if (modeReq inside {3'h2, 3'h4, 3'h6}) begin
            strap <= modeReq[2:1];
        end
    end
    assign highPin = strap[1];
    assign lowPin = strap[0];
endmodule : omsc_strap_model

//--- operating_mode_system_control_tb.sv
`timescale 1ns/1ps
module operating_mode_system_control_tb;
    import omsc_pkg::*;
    logic clk_sys;
    logic rst = 1'b1;
    logic wdtOverflowReset = 1'b0;
    logic nmiIn = 1'b0;
    logic [2:0] modeReq = 3'h2;
    logic highPin;
    logic lowPin;
    omsc_avreq_t avReq = '0;
    logic [31:0] avReadData;
    logic avWaitRequest;
    omsc_ctrlout_t ctrlOut;
    logic irq;
    logic [31:0] rd;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    omsc_strap_model u_strap (.clk_sys(clk_sys), .modeReq(modeReq),
        .highPin(highPin), .lowPin(lowPin));
    omsc_ctrl dut (.clk_sys(clk_sys), .rst(rst), .wdtOverflowReset(
        wdtOverflowReset), .modeSelectHighPin(highPin), .modeSelectLowPin(
        lowPin), .nmiIn(nmiIn), .avReq(avReq), .avReadData(avReadData),
        .avWaitRequest(avWaitRequest), .ctrlOut(ctrlOut), .irq(irq));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic print_verdict;
        $display("Checks %0d, errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [2:0] a,
        input logic [31:0] wd);
        @(posedge clk_sys);
        avReq <= '{address: a, read: !w, write: w, writedata: wd,
            byteenable: 4'h1};
        do @(posedge clk_sys); while (avWaitRequest !== 1'b0);
        rd = avReadData;
        avReq <= '0;
    endtask : bus
    task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rd_chk
    task automatic do_reset;
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask : do_reset
    task automatic t_modes;
        logic [2:0] m;
        logic [2:0] mx;
        for (int i = 0; i < 3; i++) begin
            m = 3'(2 * i + 2);
            mx = (m == 3'h2) ? 3'h4 : 3'h2;
            modeReq <= m;
            do_reset();
            check(32'(ctrlOut.opMode), 32'(m));
            check(32'(ctrlOut.emulationEnable), 32'(m == 3'h6));
            check(32'(ctrlOut.modeValid), 32'h1);
            check(32'(ctrlOut.romEnable), 32'(m != 3'h4));
            check(32'(ctrlOut.flashBoot), 32'(m == 3'h4));
            rd_chk(3'h0, 32'(m));
            bus(1'b1, 3'h0, 32'hff);
            // Strap moved on purpose to show the latch holds
            modeReq <= mx;
            repeat (3) @(posedge clk_sys);
            rd_chk(3'h0, 32'h80 | 32'(m));
            check(32'(ctrlOut.opMode), 32'(m));
            do_reset();
            rd_chk(3'h0, 32'(mx));
        end
        $display("Modes test done");
    endtask : t_modes
    task automatic t_sysctrl;
        rd_chk(3'h1, 32'h09);
        rd_chk(3'h3, 32'h0);
        bus(1'b1, 3'h1, 32'hffff_ffff);
        rd_chk(3'h1, 32'h1d);
        check(32'({ctrlOut.irqCtrlMode, ctrlOut.onchipRamEnable}), 32'h3);
        bus(1'b1, 3'h1, 32'h0);
        rd_chk(3'h1, 32'h08);
        check(32'(ctrlOut.onchipRamEnable), 32'h0);
        bus(1'b1, 3'h6, 32'hff);
        rd_chk(3'h6, 32'h0);
        $display("System control test done");
    endtask : t_sysctrl
    task automatic t_nmi;
        bus(1'b1, 3'h3, 32'h7);
        nmiIn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check(32'(ctrlOut.nmiRequest), 32'h0);
        @(posedge clk_sys);
        check(32'(irq), 32'h0);
        nmiIn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check(32'(ctrlOut.nmiRequest), 32'h1);
        @(posedge clk_sys);
        check(32'(irq), 32'h1);
        rd_chk(3'h2, 32'h1);
        bus(1'b1, 3'h2, 32'h1);
        rd_chk(3'h2, 32'h0);
        check(32'(irq), 32'h0);
        bus(1'b1, 3'h1, 32'h05);
        nmiIn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd_chk(3'h2, 32'h1);
        bus(1'b1, 3'h3, 32'h0);
        rd_chk(3'h2, 32'h1);
        check(32'(irq), 32'h0);
        bus(1'b1, 3'h2, 32'h7);
        nmiIn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd_chk(3'h2, 32'h0);
        $display("NMI test done");
    endtask : t_nmi
    task automatic t_wdt;
        @(posedge clk_sys);
        wdtOverflowReset <= 1'b1;
        @(posedge clk_sys);
        wdtOverflowReset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rd_chk(3'h1, 32'h01);
        rd_chk(3'h2, 32'h2);
        do_reset();
        rd_chk(3'h1, 32'h09);
        $display("Watchdog test done");
    endtask : t_wdt
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        t_modes();
        t_sysctrl();
        t_nmi();
        t_wdt();
        print_verdict();
    end
endmodule : operating_mode_system_control_tb
